//--- verilog/dssc_pkg.sv
// Constants for the deserializer sleep, startup and spread-rate control block
// Summary of operation
// - Audio stream never carries spread modulation.
// - Audio clock from pixel clock when source is 0.
// - Sawtooth divider sets the spread modulation rate.
// - Five-bit divider field at register 0x03 D[4:0].
// - Rate equals (1+rate pin)*pixel clock/(coef*divider).
// - Coefficient 208; divider max 15 or 30.
// - Sleep at link inactivity or 8 ms after write.
// - Sleep clears protection registers, keeps configuration.
// - Power-down tristates outputs and resets registers.
// - Leaving power-down relatches spread, rate, equalizer straps.
// - Config link only while video link disabled.
// - Control channel only after a link is established.
// - Autostart detects activity and locks to serial data.
// - Wake on lock clears sleep; 8 ms failure resleeps.
// - Normal start keeps locking, ignores wake-up pulse.
// - Mode strap high starts asleep until link enable.
package dssc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] DSSC_DIV_ADDR = 8'h03;
  localparam logic [7:0] DSSC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] DSSC_EQ_ADDR = 8'h05;
  localparam logic [7:0] DSSC_DIV_RESET = 8'h00;
  localparam int DSSC_DIV_LSB = 0;
  localparam int DSSC_DIV_W = 5;
  localparam int DSSC_SLEEP_BIT = 7;
  localparam int DSSC_SS_LSB = 0;
  localparam int DSSC_ACLK_BIT = 2;
  // ----------------------------------------------------------------
  // Spread figures
  // ----------------------------------------------------------------
  localparam logic [7:0] DSSC_RATE_COEF = 8'hd0;
  localparam logic [4:0] DSSC_DIV_MAX_4PCT = 5'h0f;
  localparam logic [4:0] DSSC_DIV_MAX_2PCT = 5'h1e;
  localparam logic [1:0] DSSC_SS_2PCT = 2'h1;
  localparam logic [1:0] DSSC_SS_4PCT = 2'h3;
  localparam logic [1:0] DSSC_SS_OFF = 2'h0;
  localparam logic [3:0] DSSC_EQ_DEF_HI = 4'h4;
  localparam logic [3:0] DSSC_EQ_DEF_LO = 4'h9;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DSSC_CLK_NS = 10;
  localparam int DSSC_SLEEP_WAIT_MS = 8;
  localparam int DSSC_SLEEP_WAIT_CYC = DSSC_SLEEP_WAIT_MS * 1000000 / DSSC_CLK_NS;
  typedef enum logic [1:0] {DSSC_RUN, DSSC_SLEEP_PEND, DSSC_ASLEEP, DSSC_WAKING} dssc_state_t;
endpackage

//--- verilog/dssc_ctrl.sv
// Sleep, power-down, startup and spread-rate control of the deserializer
`timescale 1ns/1ps
module dssc_ctrl #(
  parameter int SLEEP_WAIT_CYC = dssc_pkg::DSSC_SLEEP_WAIT_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Strap and power pins
  input wire logic power_down_n_pin,
  input wire logic spread_default_pin,
  input wire logic rate_select_pin,
  input wire logic equalizer_default_pin,
  input wire logic mode_strap_pin,
  // Serial link status
  input wire logic link_active,
  input wire logic link_locked,
  input wire logic wake_detect,
  input wire logic video_link_on,
  input wire logic config_link_on,
  // Register port from the control channel
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // Clocks in and out
  input wire logic pixel_clk_tick,
  input wire logic [7:0] audio_in,
  output logic [7:0] audio_out,
  output logic audio_clock_tick,
  output logic spread_tick,
  // Status and controls
  output logic [1:0] spread_mode,
  output logic [3:0] eq_level,
  output logic rate_sel,
  output logic asleep,
  output logic protect_clear,
  output logic outputs_oe_n,
  output logic control_ready
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    dssc_pkg::dssc_state_t st;
    logic [31:0] tmr;
    logic [7:0] div_reg;
    logic sleep_bit;
    logic aclk_src;
    logic [1:0] ss;
    logic [3:0] eq;
    logic rate;
    logic [12:0] pre;
    logic [4:0] saw;
    logic tick;
    logic aclk;
    logic [7:0] rdata;
    logic ack;
    logic pclr;
    logic [7:0] aud;
  } dssc_reg_t;
  dssc_reg_t r, next_r;

  // Effective divider, clamped to the spread's maximum so a bad write cannot stall
  function automatic logic [4:0] dssc_div_lim(input logic [4:0] d, input logic [1:0] ss);
    logic [4:0] m;
    m = (ss == dssc_pkg::DSSC_SS_4PCT) ? dssc_pkg::DSSC_DIV_MAX_4PCT
                                        : dssc_pkg::DSSC_DIV_MAX_2PCT;
    dssc_div_lim = (d == 5'h00) ? 5'h01 : ((d > m) ? m : d);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [12:0] pre_top;
    pre_top = 13'h0000;
    next_r = r;
    next_r.ack = 1'b0;
    next_r.pclr = 1'b0;
    next_r.tick = 1'b0;
    // Audio passes through untouched by any spread setting
    next_r.aud = audio_in;
    // Audio clock follows the pixel clock when source select is 0
    next_r.aclk = (r.aclk_src == 1'b0) ? pixel_clk_tick : 1'b0;
    // Sawtooth rate: prescale by coefficient, then by divider; RATE_SELECT_PIN doubles rate
    // Rate pin high halves the prescale, so the sawtooth period is halved
    pre_top = r.rate ? 13'(dssc_pkg::DSSC_RATE_COEF >> 1)
                     : 13'(dssc_pkg::DSSC_RATE_COEF);
    if (pixel_clk_tick && r.ss != dssc_pkg::DSSC_SS_OFF && r.ss != 2'h2) begin
      if (r.pre + 13'h0001 >= pre_top) begin
        next_r.pre = 13'h0000;
        if (r.saw + 5'h01 >= dssc_div_lim(r.div_reg[4:0], r.ss)) begin
          next_r.saw = 5'h00;
          next_r.tick = 1'b1;
        end else begin
          next_r.saw = r.saw + 5'h01;
        end
      end else begin
        next_r.pre = r.pre + 13'h0001;
      end
    end
    // Register writes and reads
    if (reg_wr) begin
      next_r.ack = 1'b1;
      unique case (reg_addr)
        dssc_pkg::DSSC_DIV_ADDR: next_r.div_reg = {3'h0, reg_wdata[4:0]};
        dssc_pkg::DSSC_CTRL_ADDR: begin
          next_r.ss = reg_wdata[dssc_pkg::DSSC_SS_LSB +: 2];
          next_r.aclk_src = reg_wdata[dssc_pkg::DSSC_ACLK_BIT];
          if (reg_wdata[dssc_pkg::DSSC_SLEEP_BIT] && r.st == dssc_pkg::DSSC_RUN) begin
            next_r.sleep_bit = 1'b1;
            next_r.st = dssc_pkg::DSSC_SLEEP_PEND;
            next_r.tmr = 32'h0;
          end
        end
        dssc_pkg::DSSC_EQ_ADDR: next_r.eq = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      next_r.ack = 1'b1;
      unique case (reg_addr)
        dssc_pkg::DSSC_DIV_ADDR: next_r.rdata = r.div_reg;
        dssc_pkg::DSSC_CTRL_ADDR: next_r.rdata = {r.sleep_bit, 4'h0, r.aclk_src, r.ss};
        dssc_pkg::DSSC_EQ_ADDR: next_r.rdata = {4'h0, r.eq};
        default: next_r.rdata = 8'h00;
      endcase
    end
    // Power state machine
    unique case (r.st)
      dssc_pkg::DSSC_RUN: begin
        // Normal mode locks to any serial signal; wake pulses mean nothing here
        next_r.tmr = 32'h0;
      end
      dssc_pkg::DSSC_SLEEP_PEND: begin
        next_r.tmr = r.tmr + 32'h1;
        if (!link_active || r.tmr + 32'h1 >= 32'(SLEEP_WAIT_CYC)) begin
          next_r.st = dssc_pkg::DSSC_ASLEEP;
          next_r.pclr = 1'b1;
        end
      end
      dssc_pkg::DSSC_ASLEEP: begin
        // Wake by the serializer, whether it autostarts or is enabled later
        if (wake_detect || link_active) begin
          next_r.st = dssc_pkg::DSSC_WAKING;
          next_r.tmr = 32'h0;
        end
      end
      dssc_pkg::DSSC_WAKING: begin
        next_r.tmr = r.tmr + 32'h1;
        if (link_locked) begin
          next_r.st = dssc_pkg::DSSC_RUN;
          next_r.sleep_bit = 1'b0;
        end else if (r.tmr + 32'h1 >= 32'(SLEEP_WAIT_CYC)) begin
          next_r.st = dssc_pkg::DSSC_ASLEEP;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers; power-down acts as a second synchronous reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= dssc_pkg::DSSC_RUN;
      r.div_reg <= dssc_pkg::DSSC_DIV_RESET;
    end else if (!power_down_n_pin) begin
      // Straps re-sampled every cycle while down, so the value at release is kept
      r <= '0;
      r.ss <= spread_default_pin ? dssc_pkg::DSSC_SS_2PCT : dssc_pkg::DSSC_SS_OFF;
      r.rate <= rate_select_pin;
      r.eq <= equalizer_default_pin ? dssc_pkg::DSSC_EQ_DEF_HI
                                    : dssc_pkg::DSSC_EQ_DEF_LO;
      r.st <= mode_strap_pin ? dssc_pkg::DSSC_ASLEEP : dssc_pkg::DSSC_RUN;
      r.sleep_bit <= mode_strap_pin;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign reg_ack = r.ack;
  assign audio_out = r.aud;
  assign audio_clock_tick = r.aclk;
  assign spread_tick = r.tick;
  assign spread_mode = r.ss;
  assign eq_level = r.eq;
  assign rate_sel = r.rate;
  assign asleep = (r.st == dssc_pkg::DSSC_ASLEEP);
  assign protect_clear = r.pclr;
  assign outputs_oe_n = !power_down_n_pin;
  // Control channel waits for either link while running; video and config are simply ORed
  assign control_ready = (video_link_on || config_link_on) && r.st == dssc_pkg::DSSC_RUN;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SLEEP_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_SLEEP_PEND && !link_active)
      |=> protect_clear && asleep) else $error("sleep entry missed");
  AST_WAKE_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_WAKING && link_locked)
      |=> !r.sleep_bit && r.st == dssc_pkg::DSSC_RUN) else $error("wake did not clear sleep");
  AST_PDN_OE: assert property (@(posedge clk) disable iff (!rst_n)
    !power_down_n_pin |-> outputs_oe_n) else $error("outputs driven in power-down");
  AST_PDN_STRAP: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_n_pin ##1 power_down_n_pin) |-> rate_sel == $past(rate_select_pin))
    else $error("rate strap not relatched");
  AST_DIV_FIELD: assert property (@(posedge clk) disable iff (!rst_n)
    r.div_reg[7:5] == 3'h0) else $error("divider upper bits set");
  AST_CTRL_RDY: assert property (@(posedge clk) disable iff (!rst_n)
    control_ready |-> (video_link_on || config_link_on)) else $error("control early");
  AST_AUDIO: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en) |=> audio_out == $past(audio_in)) else $error("audio altered");
  AST_ACLK: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && !r.aclk_src) |=> audio_clock_tick == $past(pixel_clk_tick))
    else $error("audio clock not from pixel clock");

  // Another source selected: the pixel-derived audio clock must stay quiet
  AST_ACLK_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.aclk_src) |=> !audio_clock_tick)
    else $error("audio clock ran with other source");

  // A sleep write from normal running arms the pending state and the bit
  AST_SLEEP_WR: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && reg_wr && reg_addr == dssc_pkg::DSSC_CTRL_ADDR &&
     reg_wdata[dssc_pkg::DSSC_SLEEP_BIT] && r.st == dssc_pkg::DSSC_RUN)
      |=> r.sleep_bit && r.st == dssc_pkg::DSSC_SLEEP_PEND)
    else $error("sleep write not taken");

  // The wait after the sleep write is bounded even with the link busy
  AST_PEND_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_SLEEP_PEND &&
     r.tmr + 32'h1 >= 32'(SLEEP_WAIT_CYC)) |=> asleep && protect_clear)
    else $error("sleep wait overran");

  // Configuration survives the way into sleep
  AST_SLEEP_KEEP_CFG: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_SLEEP_PEND && !reg_wr)
      |=> $stable(r.div_reg) && $stable(r.eq))
    else $error("configuration lost on sleep");

  // Protection clear is a single pulse, never a level
  AST_PCLR_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && protect_clear) |=> !protect_clear)
    else $error("protection clear held");

  // A failed wake attempt goes back to sleep with the bit still set
  AST_WAKE_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_WAKING && !link_locked &&
     r.tmr + 32'h1 >= 32'(SLEEP_WAIT_CYC)) |=> asleep && r.sleep_bit)
    else $error("failed wake did not resleep");

  // Normal running ignores wake pulses; only a sleep write leaves it
  AST_RUN_NO_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && r.st == dssc_pkg::DSSC_RUN &&
     !(reg_wr && reg_addr == dssc_pkg::DSSC_CTRL_ADDR && reg_wdata[dssc_pkg::DSSC_SLEEP_BIT]))
      |=> r.st == dssc_pkg::DSSC_RUN)
    else $error("normal mode left without sleep write");

  // Link activity starts a wake attempt from sleep
  AST_ASLEEP_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && asleep && link_active)
      |=> r.st == dssc_pkg::DSSC_WAKING)
    else $error("activity did not start wake");

  // Leaving power-down keeps the spread, equalizer and mode straps
  AST_PDN_SS: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_n_pin ##1 power_down_n_pin) |-> spread_mode ==
      ($past(spread_default_pin) ? dssc_pkg::DSSC_SS_2PCT : dssc_pkg::DSSC_SS_OFF))
    else $error("spread strap not relatched");
  AST_PDN_EQ: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_n_pin ##1 power_down_n_pin) |-> eq_level ==
      ($past(equalizer_default_pin) ? dssc_pkg::DSSC_EQ_DEF_HI : dssc_pkg::DSSC_EQ_DEF_LO))
    else $error("equalizer strap not relatched");
  AST_PDN_MS: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_n_pin ##1 power_down_n_pin) |-> asleep == $past(mode_strap_pin))
    else $error("mode strap not applied");

  // Power-down clears the registers and drops any answer in flight
  AST_PDN_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_n_pin ##1 power_down_n_pin) |->
      r.div_reg == dssc_pkg::DSSC_DIV_RESET && !reg_ack && !protect_clear)
    else $error("power-down left state behind");

  // Outputs are driven whenever the part is powered up
  AST_OE_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    power_down_n_pin |-> !outputs_oe_n) else $error("outputs floated while powered");

  // Sawtooth ticks only come from the two spreading modes
  AST_TICK_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    spread_tick |-> ($past(r.ss) == dssc_pkg::DSSC_SS_2PCT ||
                     $past(r.ss) == dssc_pkg::DSSC_SS_4PCT))
    else $error("spread tick with spread off");

  // Every register strobe is answered in the next cycle
  AST_ACK: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_n_pin && clk_en && (reg_wr || reg_rd)) |=> reg_ack)
    else $error("register access not acknowledged");
endmodule

//--- dv/dssc_ser_model.sv
// Behavioural serializer on the far side of the serial link
`timescale 1ns/1ps
module dssc_ser_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller settings
  input wire logic serial_link_enable,
  input wire logic config_link_enable,
  input wire logic lock_ok,
  // Link status seen by the deserializer
  output logic link_active,
  output logic link_locked,
  output logic wake_detect,
  output logic video_link_on,
  output logic config_link_on
);
  logic [3:0] age;
  // Age of the current link attempt; a link that is switched off starts over
  always_ff @(posedge clk) begin
    if (!rst_n || !link_active) age <= 4'h0;
    else if (age != 4'hf) age <= age + 4'h1;
  end
  // Lock is reached only when the bench commands it, so a failed lock can be forced
  assign link_active = serial_link_enable || config_link_enable;
  assign wake_detect = (age == 4'h3);
  assign link_locked = lock_ok && (age > 4'h5);
  assign video_link_on = link_locked && serial_link_enable;
  assign config_link_on = link_locked && config_link_enable && !serial_link_enable;
endmodule

//--- dv/dssc_ctrl_bench.sv
// Self-checking bench of the sleep, startup and spread-rate control block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module dssc_ctrl_bench;
  localparam int WAIT_CYC = 20;
  logic clk = 1'b0, rst_n = 1'b0, pdn_n = 1'b1, ss_pin = 1'b0, rate_pin = 1'b1;
  logic eq_pin = 1'b0, ms_pin = 1'b0, wr = 1'b0, rd = 1'b0, ptick = 1'b0;
  logic ser_en = 1'b0, cfg_en = 1'b0, lock_ok = 1'b0, ce = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ain = 8'h00, rdata, aout, rv, dv;
  logic ack, aclk, stick, rsel, asleep, pclr, oe_n, ready, lact, llock, wake, von, con;
  logic [1:0] ssm;
  logic [3:0] eq;
  int err_total = 0, checks_done = 0, n, seen;
  always #5 clk = ~clk;
  dssc_ser_model i_ser (.clk(clk), .rst_n(rst_n), .serial_link_enable(ser_en),
    .config_link_enable(cfg_en), .lock_ok(lock_ok), .link_active(lact), .link_locked(llock),
    .wake_detect(wake), .video_link_on(von), .config_link_on(con));
  dssc_ctrl #(.SLEEP_WAIT_CYC(WAIT_CYC)) i_dut (.clk(clk), .rst_n(rst_n), .clk_en(ce),
    .power_down_n_pin(pdn_n), .spread_default_pin(ss_pin), .rate_select_pin(rate_pin),
    .equalizer_default_pin(eq_pin), .mode_strap_pin(ms_pin), .link_active(lact),
    .link_locked(llock), .wake_detect(wake), .video_link_on(von), .config_link_on(con),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_ack(ack), .pixel_clk_tick(ptick), .audio_in(ain), .audio_out(aout),
    .audio_clock_tick(aclk), .spread_tick(stick), .spread_mode(ssm), .eq_level(eq),
    .rate_sel(rsel), .asleep(asleep), .protect_clear(pclr), .outputs_oe_n(oe_n),
    .control_ready(ready));
  // ----------------------------------------------------------------
  // Closing and register access
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One strobe, answer sampled in the following cycle
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w; rd <= !w; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1 `CHK(ack, 1'b1)
    rv = rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Spread period measured between two ticks; bounded so a silent divider cannot hang
  task automatic period(input int exp);
    n = 0;
    while (!stick && n < 4000) begin @(posedge clk); #1 n++; end
    n = 0;
    do begin @(posedge clk); #1 n++; end while (!stick && n < 4000);
    `CHK(n, exp)
  endtask
  // Watchdog sized well beyond the expected run
  initial begin
    #500000;
    err_total++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(67));
    cyc(12);
    rst_n <= 1'b1;
    acc(1'b0, dssc_pkg::DSSC_DIV_ADDR, 8'h00); `CHK(rv, dssc_pkg::DSSC_DIV_RESET)
    acc(1'b0, 8'hff, 8'h00); `CHK(rv, 8'h00)
    dv = 8'($urandom); // random divider field, upper bits must read back zero
    acc(1'b1, dssc_pkg::DSSC_DIV_ADDR, dv | 8'he0);
    acc(1'b0, dssc_pkg::DSSC_DIV_ADDR, 8'h00); `CHK(rv, {3'h0, dv[4:0]})
    // Audio passes unchanged, audio clock follows pixel ticks with source 0
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      ain <= 8'($urandom); ptick <= 1'($urandom);
      @(posedge clk);
      #1 `CHK(aout, ain)
      `CHK(aclk, ptick)
    end
    // Clock enable low freezes every register, audio included
    rv = aout; ce <= 1'b0; ain <= ~aout; cyc(3);
    #1 `CHK(aout, rv)
    ce <= 1'b1;
    // Spread period: 4 percent clamps at 15; rate is zero after reset, full coefficient
    ptick <= 1'b1;
    acc(1'b1, dssc_pkg::DSSC_CTRL_ADDR, {6'h00, dssc_pkg::DSSC_SS_4PCT});
    acc(1'b1, dssc_pkg::DSSC_DIV_ADDR, 8'h02); period(2 * 208);
    acc(1'b1, dssc_pkg::DSSC_DIV_ADDR, 8'h1f); period(15 * 208);
    acc(1'b1, dssc_pkg::DSSC_CTRL_ADDR, {6'h00, dssc_pkg::DSSC_SS_2PCT});
    acc(1'b1, dssc_pkg::DSSC_DIV_ADDR, 8'h01); period(208);
    // Sleep with link active waits out the full count, then clears protection
    ser_en <= 1'b1; lock_ok <= 1'b1; cyc(10);
    #1 `CHK(ready, 1'b1)
    acc(1'b1, dssc_pkg::DSSC_CTRL_ADDR, 8'h80);
    seen = 0; n = 0;
    while (!asleep && n < 40) begin @(posedge clk); #1 n++; seen += pclr; end
    `CHK(n >= WAIT_CYC - 2 && n <= WAIT_CYC + 2, 1'b1)
    `CHK(seen > 0 || pclr, 1'b1)
    ser_en <= 1'b0; cyc(WAIT_CYC + 10);
    // Failed lock falls back asleep with the bit still set
    acc(1'b0, dssc_pkg::DSSC_DIV_ADDR, 8'h00); `CHK(rv, 8'h01)
    lock_ok <= 1'b0; ser_en <= 1'b1; cyc(8); ser_en <= 1'b0; cyc(WAIT_CYC + 10);
    #1 `CHK(asleep, 1'b1)
    acc(1'b0, dssc_pkg::DSSC_CTRL_ADDR, 8'h00); `CHK(rv[7], 1'b1)
    // Successful lock wakes and clears the bit
    lock_ok <= 1'b1; cfg_en <= 1'b1; cyc(12);
    #1 `CHK(asleep, 1'b0)
    `CHK(ready, 1'b1)
    acc(1'b0, dssc_pkg::DSSC_CTRL_ADDR, 8'h00); `CHK(rv[7], 1'b0)
    // Power-down tristates outputs and relatches the straps
    cfg_en <= 1'b0; pdn_n <= 1'b0; ss_pin <= 1'b1; rate_pin <= 1'b0; ms_pin <= 1'b1;
    cyc(3);
    #1 `CHK(oe_n, 1'b1)
    pdn_n <= 1'b1; cyc(2);
    #1 `CHK(ssm, dssc_pkg::DSSC_SS_2PCT)
    `CHK(eq, dssc_pkg::DSSC_EQ_DEF_LO)
    `CHK(rsel, 1'b0)
    `CHK(asleep, 1'b1)
    `CHK(ready, 1'b0)
    period(208);
    // Rate pin high latched on release halves the sawtooth period
    pdn_n <= 1'b0; rate_pin <= 1'b1; cyc(2);
    pdn_n <= 1'b1; cyc(2);
    #1 `CHK(rsel, 1'b1)
    period(104);
    test_done();
  end
endmodule
